// >>> src/sow_engine.sv
// sanitize command checker and overwrite fill generator
// assumes an Avalon-MM master on the register port and a media writer on the fill port
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module sow_engine (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // fill stream to media
    output logic             fill_valid,
    input  wire logic        fill_ready,
    output logic [7:0]       fill_data,
    output logic             fill_pi,
    output logic             fill_last,
    // media side events
    input  wire logic        media_fail,
    output logic             key_replace
);
    typedef enum logic [2:0] {ST_IDLE, ST_DECODE, ST_HDR, ST_PAT, ST_FILL, ST_DONE} sow_state_t;

    sow_state_t          state_r;
    sow_pkg::sow_cdb_t   cdb_r;
    sow_pkg::sow_sense_t sense_r;
    logic [15:0]         plen_r;
    logic [15:0]         blklen_r;
    logic                pi_en_r;
    logic [15:0]         blkcnt_r;
    logic                wait_r;
    logic [31:0]         rdata_r;
    logic                done_r;
    logic                cc_r;
    logic                early_r;
    logic                failed_r;
    logic                permit_r;
    logic [7:0]          keygen_r;
    logic                key_r;
    logic                inv_r;
    logic [7:0]          cnt_r;
    logic [15:0]         len_r;
    logic [1:0]          hdr_r;
    logic [7:0]          pat_r [sow_pkg::PAT_MAX];
    logic [15:0]         pidx_r;
    logic [16:0]         byte_r;
    logic [15:0]         blk_r;
    logic [7:0]          pass_r;
    logic [7:0]          mask_r;
    logic                fv_r;
    logic [7:0]          fd_r;
    logic                fpi_r;
    logic                flast_r;
    // combinational
    logic                acc;
    logic                wr_param;
    logic                start;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic [7:0]          fifo_out_data;
    logic                pop;
    logic                in_dec;
    logic                ev_cdb_err;
    logic                ev_exit_bad;
    logic                ev_exit_ok;
    logic                ev_crypto;
    logic [15:0]         hdr_len;
    logic                ev_par_err;
    logic                ev_media;
    logic                ev_end;
    logic                load;
    logic [16:0]         blk_total;
    logic                in_pi;
    logic                blk_end;
    logic                pass_end;
    logic                fill_end;
    logic [7:0]          gen;

    // reserved service action codes
    function automatic logic is_rsvd(input logic [4:0] sa);
        return !(sa == sow_pkg::SA_OVW || sa == sow_pkg::SA_CRY || sa == sow_pkg::SA_EXIT);
    endfunction

    // bus request accepted at the edge where waitrequest is low
    assign acc      = (avs_read || avs_write) && !wait_r;
    assign wr_param = acc && avs_write && (avs_address == sow_pkg::OFS_PARAM);
    assign start    = acc && avs_write && (avs_address == sow_pkg::OFS_CMD)
                      && avs_writedata[sow_pkg::CMD_START] && (state_r == ST_IDLE);

    // parameter byte buffer
    sow_fifo #(
        .W(sow_pkg::FIFO_W),
        .D(sow_pkg::FIFO_D)
    ) u_fifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .in_valid (wr_param),
        .in_ready (fifo_in_ready),
        .in_data  (avs_writedata[7:0]),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data (fifo_out_data)
    );

    // waitrequest and read data; parameter writes stall while the fifo is full
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h0;
        end else if (wait_r && (avs_read || avs_write)) begin
            if (!(avs_write && avs_address == sow_pkg::OFS_PARAM && !fifo_in_ready)) begin
                wait_r <= 1'b0;
            end
            case (avs_address)
                sow_pkg::OFS_CMD:    rdata_r <= {8'h0, plen_r, cdb_r};
                sow_pkg::OFS_GEOM:   rdata_r <= {15'h0, pi_en_r, blklen_r};
                sow_pkg::OFS_BLKCNT: rdata_r <= {16'h0, blkcnt_r};
                sow_pkg::OFS_STATUS: rdata_r <= {keygen_r, sense_r.asc, 4'h0, sense_r.key,
                                                 3'h0, permit_r, failed_r, cc_r, done_r,
                                                 (state_r != ST_IDLE)};
                default:             rdata_r <= 32'h0;
            endcase
        end else begin
            wait_r <= 1'b1;
        end
    end

    // software-written registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cdb_r    <= '0;
            plen_r   <= 16'h0;
            blklen_r <= sow_pkg::RST_BLKLEN;
            pi_en_r  <= 1'b0;
            blkcnt_r <= sow_pkg::RST_BLKCNT;
        end else if (start) begin
            cdb_r  <= avs_writedata[7:0];
            plen_r <= avs_writedata[sow_pkg::CMD_LEN_LSB +: 16];
        end else if (acc && avs_write && state_r == ST_IDLE) begin
            if (avs_address == sow_pkg::OFS_GEOM) begin
                blklen_r <= avs_writedata[15:0];
                pi_en_r  <= avs_writedata[sow_pkg::GEOM_PI];
            end
            if (avs_address == sow_pkg::OFS_BLKCNT) begin
                blkcnt_r <= avs_writedata[15:0];
            end
        end
    end

    // command decode and parse events
    always_comb begin
        in_dec      = (state_r == ST_DECODE);
        ev_cdb_err  = in_dec && (is_rsvd(cdb_r.sa)
                      || (cdb_r.sa != sow_pkg::SA_OVW && plen_r != 16'h0));
        ev_exit_bad = in_dec && !ev_cdb_err && cdb_r.sa == sow_pkg::SA_EXIT
                      && failed_r && !permit_r;
        ev_exit_ok  = in_dec && !ev_cdb_err && cdb_r.sa == sow_pkg::SA_EXIT
                      && failed_r && permit_r;
        ev_crypto   = in_dec && !ev_cdb_err && cdb_r.sa == sow_pkg::SA_CRY;
        pop         = ((state_r == ST_HDR || state_r == ST_PAT || state_r == ST_DONE))
                      && fifo_out_valid;
        hdr_len     = {len_r[7:0], fifo_out_data};
        ev_par_err  = state_r == ST_HDR && pop && hdr_r == sow_pkg::HDR_LAST
                      && (cnt_r == 8'h0
                      || hdr_len == 16'h0 || hdr_len > blklen_r
                      || hdr_len > 16'(sow_pkg::PAT_MAX));
        ev_media    = (state_r == ST_FILL) && media_fail;
        ev_end      = (state_r == ST_DONE) && !fv_r && !fifo_out_valid;
    end

    // fill position decode
    always_comb begin
        blk_total = {1'b0, blklen_r} + (pi_en_r ? 17'(sow_pkg::PI_BYTES) : 17'h0);
        in_pi     = (byte_r >= {1'b0, blklen_r});
        blk_end   = (byte_r == blk_total - 17'h1);
        pass_end  = blk_end && (blk_r == blkcnt_r - 16'h1);
        fill_end  = pass_end && (pass_r == cnt_r - 8'h1);
        load      = (state_r == ST_FILL) && !media_fail && (!fv_r || fill_ready);
        gen       = (in_pi ? sow_pkg::PI_FILL : pat_r[pidx_r[5:0]]) ^ mask_r;
    end

    // sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        state_r <= ST_DECODE;
                    end
                end
                ST_DECODE: begin
                    if (!ev_cdb_err && cdb_r.sa == sow_pkg::SA_OVW) begin
                        state_r <= ST_HDR;
                    end else begin
                        state_r <= ST_DONE;
                    end
                end
                ST_HDR: begin
                    if (ev_par_err) begin
                        state_r <= ST_DONE;
                    end else if (pop && hdr_r == sow_pkg::HDR_LAST) begin
                        state_r <= ST_PAT;
                    end
                end
                ST_PAT: begin
                    if (pop && pidx_r == len_r - 16'h1) begin
                        state_r <= (blkcnt_r == 16'h0) ? ST_DONE : ST_FILL;
                    end
                end
                ST_FILL: begin
                    if (ev_media || (load && fill_end)) begin
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (ev_end) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // header capture; test bits of byte 0 are dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hdr_r <= 2'h0;
            inv_r <= 1'b0;
            cnt_r <= 8'h0;
            len_r <= 16'h0;
        end else if (in_dec) begin
            hdr_r <= 2'h0;
        end else if (state_r == ST_HDR && pop) begin
            hdr_r <= hdr_r + 2'h1;
            case (hdr_r)
                2'h0: begin
                    inv_r <= fifo_out_data[7];
                    cnt_r <= {3'h0, fifo_out_data[4:0]};
                end
                2'h2: len_r <= {8'h0, fifo_out_data};
                2'h3: len_r <= hdr_len;
                default: ;
            endcase
        end
    end

    // pattern storage
    always_ff @(posedge clk) begin
        if (state_r == ST_PAT && pop) begin
            pat_r[pidx_r[5:0]] <= fifo_out_data;
        end
    end

    // pattern index, block, pass and invert mask
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pidx_r <= 16'h0;
            byte_r <= 17'h0;
            blk_r  <= 16'h0;
            pass_r <= 8'h0;
            mask_r <= 8'h0;
        end else if (state_r == ST_HDR) begin
            pidx_r <= 16'h0;
            byte_r <= 17'h0;
            blk_r  <= 16'h0;
            pass_r <= 8'h0;
            mask_r <= 8'h0;
        end else if (state_r == ST_PAT && pop) begin
            pidx_r <= (pidx_r == len_r - 16'h1) ? 16'h0 : pidx_r + 16'h1;
        end else if (load) begin
            if (blk_end) begin
                byte_r <= 17'h0;
                pidx_r <= 16'h0;
                blk_r  <= pass_end ? 16'h0 : blk_r + 16'h1;
                if (pass_end) begin
                    pass_r <= pass_r + 8'h1;
                    mask_r <= mask_r ^ {8{inv_r}};
                end
            end else begin
                byte_r <= byte_r + 17'h1;
                if (!in_pi) begin
                    pidx_r <= (pidx_r == len_r - 16'h1) ? 16'h0 : pidx_r + 16'h1;
                end
            end
        end
    end

    // fill output stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fv_r    <= 1'b0;
            fd_r    <= 8'h0;
            fpi_r   <= 1'b0;
            flast_r <= 1'b0;
        end else if (load) begin
            fv_r    <= 1'b1;
            fd_r    <= gen;
            fpi_r   <= in_pi;
            flast_r <= fill_end;
        end else if (fill_ready) begin
            fv_r <= 1'b0;
        end
    end

    // status, sense and sanitize-failed state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_r   <= 1'b0;
            cc_r     <= 1'b0;
            early_r  <= 1'b0;
            sense_r  <= '0;
            failed_r <= 1'b0;
            permit_r <= 1'b0;
        end else if (start) begin
            done_r  <= 1'b0;
            cc_r    <= 1'b0;
            sense_r <= '0;
        end else if (in_dec) begin
            early_r <= cdb_r.immed;
            done_r  <= ev_cdb_err || ev_exit_bad || cdb_r.immed;
            cc_r    <= ev_cdb_err || ev_exit_bad;
            if (ev_cdb_err || ev_exit_bad) begin
                sense_r <= '{key: sow_pkg::SK_ILLEGAL, asc: sow_pkg::ASC_CDB};
            end
            if (ev_exit_ok) begin
                failed_r <= 1'b0;
            end
        end else if (ev_par_err) begin
            cc_r    <= !early_r;
            sense_r <= '{key: sow_pkg::SK_ILLEGAL, asc: sow_pkg::ASC_PARAM};
        end else if (ev_media) begin
            cc_r     <= !early_r;
            sense_r  <= '{key: sow_pkg::SK_MEDIUM, asc: sow_pkg::ASC_MEDIUM};
            failed_r <= 1'b1;
            permit_r <= cdb_r.permit;
        end else if (ev_end) begin
            done_r <= 1'b1;
        end
    end

    // key generation count and replace pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            keygen_r <= 8'h0;
            key_r    <= 1'b0;
        end else begin
            key_r <= ev_crypto;
            if (ev_crypto) begin
                keygen_r <= keygen_r + 8'h1;
            end
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata    = rdata_r;
    assign fill_valid      = fv_r;
    assign fill_data       = fd_r;
    assign fill_pi         = fpi_r;
    assign fill_last       = flast_r;
    assign key_replace     = key_r;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_crypto_dec;
        in_dec && !ev_cdb_err && cdb_r.sa == sow_pkg::SA_CRY;
    endsequence
    sequence s_key_out;
        key_r && keygen_r == $past(keygen_r) + 8'h1;
    endsequence

    AST_RSV_SA: assert property (in_dec && is_rsvd(cdb_r.sa) |=>
        cc_r && done_r && sense_r.key == sow_pkg::SK_ILLEGAL && sense_r.asc == sow_pkg::ASC_CDB)
        else $error("reserved service action not rejected");
    AST_OVW_ONLY: assert property (state_r == ST_FILL |-> cdb_r.sa == sow_pkg::SA_OVW)
        else $error("fill without overwrite");
    AST_CRYPTO: assert property (s_crypto_dec |=> s_key_out)
        else $error("key not replaced");
    AST_EXIT_OK: assert property (ev_exit_ok |=> !failed_r && !cc_r
        && done_r == $past(cdb_r.immed))
        else $error("exit failure mode not honoured");
    AST_EXIT_BAD: assert property (ev_exit_bad |=> failed_r && cc_r)
        else $error("exit failure mode not rejected");
    AST_PLEN: assert property (in_dec && cdb_r.sa != sow_pkg::SA_OVW && plen_r != 16'h0
        |=> cc_r && sense_r.asc == sow_pkg::ASC_CDB)
        else $error("nonzero parameter length accepted");
    AST_EARLY: assert property (in_dec && cdb_r.immed && !ev_cdb_err && !ev_exit_bad
        |=> done_r && !cc_r ##1 done_r && !cc_r)
        else $error("early good status missing");
    AST_LATE: assert property (in_dec && !cdb_r.immed && cdb_r.sa == sow_pkg::SA_OVW
        && !ev_cdb_err |=> !done_r)
        else $error("status before overwrite end");
    AST_PAR_ERR: assert property (ev_par_err |=> cc_r == !early_r
        && sense_r.asc == sow_pkg::ASC_PARAM && state_r == ST_DONE)
        else $error("bad pattern length not rejected");
    AST_BLK_START: assert property (load && byte_r == 17'h0 |=>
        fd_r == (pat_r[0] ^ $past(mask_r)))
        else $error("block does not start at pattern byte 0");
    AST_PI_FILL: assert property (load && in_pi |=> fpi_r && fd_r == ($past(mask_r) ^ 8'hff))
        else $error("protection bytes wrong");
    AST_NO_INV: assert property (state_r == ST_FILL && !inv_r |-> mask_r == 8'h0)
        else $error("pattern altered without invert");
    AST_INV: assert property (load && pass_end && inv_r |=> mask_r == ~$past(mask_r))
        else $error("pass not inverted");
endmodule

// >>> src/sow_pkg.sv
// constants, field layouts and carrier types of the sanitize overwrite engine
// assumes one 40 MHz clock and an Avalon-MM master reaching the registers
//
// What this block does
// - A reserved service action code ends the command with check condition, illegal request, invalid field in CDB.
// - The overwrite service action writes the pattern to the medium once per requested pass.
// - The cryptographic erase service action replaces the internal key so old data cannot be read.
// - Exit failure mode leaves the failed state when the failed command had the exit permit bit set.
// - Exit failure mode is rejected when the failed command had the exit permit bit clear.
// - Any service action other than overwrite needs a zero parameter list length, else illegal request.
// - Early status clear reports status at the end; early status set reports good status at once.
// - The pass count gives the number of passes; a zero count ends with invalid field in parameter list.
// - With invert clear, pattern and protection bytes are written unchanged on every pass.
// - With invert set, pattern and protection bytes are complemented from each pass to the next.
// - Parameter bytes 2 and 3, high byte first, give the pattern length; the pattern starts at byte 4.
// - A zero pattern length or one above the block length ends with invalid field in parameter list.
// - The pattern repeats as often as needed to fill the user data of each block.
// - Each block starts again at the first pattern byte.
// - Protection information bytes are all ones in every overwritten block of an uncomplemented pass.
package sow_pkg;
    // register byte offsets
    localparam logic [4:0] OFS_CMD    = 5'h00;
    localparam logic [4:0] OFS_PARAM  = 5'h04;
    localparam logic [4:0] OFS_GEOM   = 5'h08;
    localparam logic [4:0] OFS_BLKCNT = 5'h0c;
    localparam logic [4:0] OFS_STATUS = 5'h10;
    // command and geometry register fields
    localparam int CMD_LEN_LSB = 8;
    localparam int CMD_START   = 31;
    localparam int GEOM_PI     = 16;
    // reset values
    localparam logic [15:0] RST_BLKLEN = 16'h0200;
    localparam logic [15:0] RST_BLKCNT = 16'h0001;
    // service actions
    localparam logic [4:0] SA_OVW  = 5'h01;
    localparam logic [4:0] SA_CRY  = 5'h03;
    localparam logic [4:0] SA_EXIT = 5'h1f;
    // sense data
    localparam logic [3:0] SK_ILLEGAL = 4'h5;
    localparam logic [3:0] SK_MEDIUM  = 4'h3;
    localparam logic [7:0] ASC_CDB    = 8'h24;
    localparam logic [7:0] ASC_PARAM  = 8'h26;
    localparam logic [7:0] ASC_MEDIUM = 8'h31;
    // overwrite geometry
    localparam int         PAT_MAX  = 64;
    localparam logic [4:0] PI_BYTES = 5'h08;
    localparam logic [7:0] PI_FILL  = 8'hff;
    localparam int         FIFO_W   = 8;
    localparam int         FIFO_D   = 32;
    localparam logic [1:0] HDR_LAST = 2'h3;

    // cdb byte 1 as received
    typedef struct packed {
        logic       immed;
        logic       rsvd;
        logic       permit;
        logic [4:0] sa;
    } sow_cdb_t;

    // sense data carried with status
    typedef struct packed {
        logic [3:0] key;
        logic [7:0] asc;
    } sow_sense_t;
endpackage

// >>> src/sow_fifo.sv
// byte fifo between the register port and the parameter list parser
// assumes one clock; push and pop follow valid/ready handshakes
`timescale 1ns/1ps
module sow_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_r [D];
    logic [AW:0]  wp_r;
    logic [AW:0]  rp_r;
    logic         full;
    logic         empty;

    // flags from pointers with wrap bit
    assign empty     = (wp_r == rp_r);
    assign full      = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_r[rp_r[AW-1:0]];

    // write side
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
        end else if (in_valid && !full) begin
            wp_r <= wp_r + 1'b1;
        end
    end

    // storage
    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem_r[wp_r[AW-1:0]] <= in_data;
        end
    end

    // read side
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rp_r <= '0;
        end else if (out_ready && !empty) begin
            rp_r <= rp_r + 1'b1;
        end
    end
endmodule

// >>> tb/sow_media.sv
// media writer model on the fill port, stalling one cycle in four
// assumes the engine holds fill outputs until they are accepted
`timescale 1ns/1ps
module sow_media (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // fill stream
    input  wire logic fill_valid,
    output logic      fill_ready,
    input  wire logic [7:0] fill_data,
    input  wire logic fill_pi,
    input  wire logic fill_last,
    // fault control from the bench
    input  wire logic fail_en,
    output logic      media_fail
);
    logic [1:0] ph;
    logic [9:0] q[$];
    // record every accepted byte with its flags
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) ph <= 2'h0;
        else begin
            ph <= ph + 2'h1;
            if (fill_valid && fill_ready) q.push_back({fill_last, fill_pi, fill_data});
        end
    end
    assign fill_ready = (ph != 2'h3); // slow answer every fourth cycle
    assign media_fail = fail_en && fill_valid;
endmodule

// >>> tb/tb_sanitize_overwrite_engine.sv
// bench: command table, overwrite fill contents, failure and exit
// assumes the media model on the fill port
`timescale 1ns/1ps
module tb_sanitize_overwrite_engine;
    typedef struct {logic [7:0] b1; logic [15:0] len; logic [7:0] b0; logic [7:0] s;} sow_row_t;
    logic clk = 0, rst_n = 0, rd = 0, wr = 0, fe = 0, wq, fv, fr, fp, fl, mf, kr;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wd = 32'h0, rdr, rdat;
    logic [7:0]  fd;
    int mismatches = 0, n_checks = 0, cyc = 0, kg = 0, kp = 0;
    logic fx = 1'b0, pm = 1'b0; // expected sanitize-failed state and its exit permit
    sow_row_t rows[12] = '{'{8'h00, 16'h0, 8'h0, 8'h24}, '{8'h02, 16'h0, 8'h0, 8'h24},
        '{8'h04, 16'h0, 8'h0, 8'h24}, '{8'h1e, 16'h0, 8'h0, 8'h24}, '{8'h03, 16'h0, 8'h0, 8'h0},
        '{8'h03, 16'h4, 8'h0, 8'h24}, '{8'h83, 16'h0, 8'h0, 8'h0}, '{8'h1f, 16'h0, 8'h0, 8'h0},
        '{8'h01, 16'h1, 8'h00, 8'h26}, '{8'h01, 16'h0, 8'h01, 8'h26},
        '{8'h01, 16'h6, 8'h01, 8'h26}, '{8'h01, 16'h3, 8'he2, 8'h0}};
    sow_engine DUT (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_readdata(rdr), .avs_waitrequest(wq), .fill_valid(fv),
        .fill_ready(fr), .fill_data(fd), .fill_pi(fp), .fill_last(fl), .media_fail(mf),
        .key_replace(kr));
    sow_media u_media (.clk(clk), .rst_n(rst_n), .fill_valid(fv), .fill_ready(fr),
        .fill_data(fd), .fill_pi(fp), .fill_last(fl), .fail_en(fe), .media_fail(mf));
    // clock and hang limit
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (kr === 1'b1) kp++;
        if (cyc == 20000) begin
            mismatches++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (wq !== 1'b0);
        rdat = rdr;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // push parameters, start, wait idle and compare status
    task automatic run(input sow_row_t r);
        logic ow;
        ow = (r.b1[4:0] === sow_pkg::SA_OVW);
        if (ow) begin
            bus(1'b1, sow_pkg::OFS_PARAM, {24'h0, r.b0});
            bus(1'b1, sow_pkg::OFS_PARAM, 32'h0);
            bus(1'b1, sow_pkg::OFS_PARAM, {24'h0, r.len[15:8]});
            bus(1'b1, sow_pkg::OFS_PARAM, {24'h0, r.len[7:0]});
            for (int i = 0; i < r.len; i++) bus(1'b1, sow_pkg::OFS_PARAM, 32'ha1 + 32'h11 * i);
        end
        bus(1'b1, sow_pkg::OFS_CMD, {8'h80, r.len + (ow ? 16'h4 : 16'h0), r.b1});
        do bus(1'b0, sow_pkg::OFS_STATUS, 32'h0); while (rdat[1:0] !== 2'b10);
        if (r.b1[4:0] === sow_pkg::SA_CRY && r.len == 16'h0) kg++;
        if (r.s == 8'h31) begin
            fx = 1'b1;
            pm = r.b1[5];
        end else if (r.b1 == 8'h1f && pm) fx = 1'b0;
        check({rdat[31:16], rdat[11:8], rdat[3:2]}, {kg[7:0], r.s,
            (r.s == 8'h31) ? 4'h3 : (r.s != 8'h0) ? 4'h5 : 4'h0, fx, r.s != 8'h0});
    endtask
    // reset, table, fill contents, then failure and exit
    initial begin
        logic [9:0] e;
        repeat (16) @(posedge clk);
        check(rdr, 32'h0);
        check({29'h0, wq, fv, kr}, {29'h0, 3'b100});
        rst_n <= 1'b1;
        bus(1'b0, sow_pkg::OFS_GEOM, 32'h0);
        check(rdat, 32'h200);
        bus(1'b0, 5'h14, 32'h0);
        check(rdat, 32'h0);
        bus(1'b1, sow_pkg::OFS_GEOM, 32'h0001_0005);
        bus(1'b1, sow_pkg::OFS_BLKCNT, 32'h2);
        foreach (rows[i]) run(rows[i]);
        $display("command table done");
        check(kp, kg);
        check(u_media.q.size(), 32'd52);
        for (int k = 0; k < 52; k++) begin
            e = (k % 13 < 5) ? {2'b00, 8'ha1 + 8'h11 * ((k % 13) % 3)} : 10'h1ff;
            check(u_media.q[k], e ^ ((k >= 26) ? 10'h0ff : 10'h0) ^ ((k == 51) ? 10'h200 : 10'h0));
        end
        $display("fill done");
        fe <= 1'b1;
        run('{8'h21, 16'h3, 8'h01, 8'h31});
        fe <= 1'b0;
        run('{8'h1f, 16'h0, 8'h0, 8'h0});
        $display("failure exit done");
        fe <= 1'b1;
        run('{8'h01, 16'h3, 8'h01, 8'h31});
        fe <= 1'b0;
        run('{8'h1f, 16'h0, 8'h0, 8'h24});
        $display("exit refusal done");
        close_out();
    end
endmodule
